// [sim/ioc_host_model.sv]
// serial host model: mode 3 frames, MSB first, returned word captured
`timescale 1ns/1ps
module ioc_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_reg
);
    // idle: clock high, deselected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // half period of four clocks leaves margin over the one-clock edge detect
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            din <= tx[i];
            repeat (4) @(posedge mclk);
            rx[i] = dout_reg;
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        cs_n <= 1'b1;
        din <= ~tx[0]; // released line shows the inverse, not a stale bit
        repeat (4) @(posedge mclk);
    endtask : xfer
endmodule : ioc_host_model

// [sim/ioc_top_assertions.sv]
// port-level timing checks of the calibration stage
`timescale 1ns/1ps
module ioc_top_assertions
    import ioc_pkg::*;
#(
    parameter int FLASH_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout_reg,
    input wire logic sample_valid,
    input wire ioc_sample_t x_accel_raw,
    input wire ioc_sample_t y_accel_raw,
    input wire ioc_sample_t x_tilt_raw,
    input wire ioc_sample_t y_tilt_raw,
    input wire logic flash_busy_reg
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    int busy_cnt;
    // busy span is far beyond a repetition count, so it is counted here
    always_ff @(posedge mclk) begin
        busy_cnt <= (reset || !flash_busy_reg) ? 0 : busy_cnt + 1;
    end
    sequence s_busy_start;
        !flash_busy_reg ##1 flash_busy_reg;
    endsequence
    sequence s_clk_high;
        (!cs_n && sclk) [*2];
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rst_dout;
        reset |=> !dout_reg;
    endproperty
    a_rst_dout: assert property (p_rst_dout) else $error("dout not cleared");
    property p_rst_busy;
        reset |=> !flash_busy_reg;
    endproperty
    a_rst_busy: assert property (p_rst_busy) else $error("busy not cleared");
    property p_busy_len;
        disable iff (reset) $fell(flash_busy_reg) && !$past(reset) |-> busy_cnt == FLASH_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
    property p_busy_max;
        disable iff (reset) busy_cnt <= FLASH_CYCLES;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_busy_hold;
        disable iff (reset) s_busy_start |=> flash_busy_reg [*7];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    // commit starts only just after a frame's last rising serial edge
    property p_busy_cause;
        disable iff (reset) $rose(flash_busy_reg) |-> !$past(cs_n) && $past(sclk);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
    property p_dout_hold;
        disable iff (reset) s_clk_high |-> $stable(dout_reg);
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("dout moved while clock high");
    property p_dout_edge;
        disable iff (reset) !cs_n && !$past(cs_n) && $changed(dout_reg) |-> !sclk;
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("dout moved off falling edge");
endmodule : ioc_top_assertions

bind ioc_top ioc_top_assertions #(.FLASH_CYCLES(FLASH_CYCLES)) u_chk (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_reg(dout_reg),
    .sample_valid(sample_valid), .x_accel_raw(x_accel_raw), .y_accel_raw(y_accel_raw),
    .x_tilt_raw(x_tilt_raw), .y_tilt_raw(y_tilt_raw), .flash_busy_reg(flash_busy_reg)
);

// [sim/testbench.sv]
// self-checking bench for the calibration stage
`timescale 1ns/1ps
module testbench
    import ioc_pkg::*;
;
    localparam int FLASH_CYCLES = 20;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic sample_valid = 1'b0;
    ioc_sample_t x_accel_raw = 14'h0000;
    ioc_sample_t y_accel_raw = 14'h0000;
    ioc_sample_t x_tilt_raw = 14'h0000;
    ioc_sample_t y_tilt_raw = 14'h0000;
    logic sclk, cs_n, din, dout_reg, flash_busy_reg;
    ioc_word_t rx;
    int n_fail = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    ioc_top #(.FLASH_CYCLES(FLASH_CYCLES)) u_dut (
        .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_reg(dout_reg),
        .sample_valid(sample_valid), .x_accel_raw(x_accel_raw), .y_accel_raw(y_accel_raw),
        .x_tilt_raw(x_tilt_raw), .y_tilt_raw(y_tilt_raw), .flash_busy_reg(flash_busy_reg)
    );
    ioc_host_model u_host (
        .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_reg(dout_reg)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic ioc_addr_t cal_addr(input int i);
        return 6'h10 + 6'(2 * i);
    endfunction : cal_addr
    function automatic ioc_word_t dflt(input int i);
        return (i % 4 >= 2) ? 16'h0800 : 16'h0000;
    endfunction : dflt
    function automatic ioc_word_t mask(input int i);
        return (i / 2 == 2) ? 16'h01FF : 16'h0FFF;
    endfunction : mask
    task automatic wr(input ioc_addr_t a, input logic [7:0] d);
        u_host.xfer({2'b10, a, d}, rx);
    endtask : wr
    task automatic wr16(input ioc_addr_t a, input ioc_word_t v);
        wr(a | 6'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    // the answer arrives in the next frame, which carries a harmless read
    task automatic rd_chk(input string what, input ioc_addr_t a, input ioc_word_t exp);
        ioc_word_t v;
        u_host.xfer({2'b00, a, 8'h00}, rx);
        u_host.xfer(16'h0000, v);
        check(what, v, exp);
    endtask : rd_chk
    task automatic pulse;
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : pulse

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults;
        for (int i = 0; i < 8; i++) begin
            rd_chk("default", cal_addr(i), dflt(i));
            rd_chk("odd read", cal_addr(i) | 6'h01, dflt(i));
        end
    endtask : t_defaults
    task automatic t_masks;
        for (int i = 0; i < 8; i++) begin
            wr16(cal_addr(i), 16'hFFFF);
            rd_chk("field mask", cal_addr(i), mask(i));
            wr16(cal_addr(i), dflt(i));
        end
        wr(6'h10, 8'h5A);
        rd_chk("low byte", 6'h10, 16'h005A);
        wr(6'h11, 8'h03);
        rd_chk("high byte", 6'h11, 16'h035A);
        wr16(6'h10, 16'h0000);
        wr(6'h2A, 8'hFF);
        rd_chk("unmapped", 6'h2A, 16'h0000);
    endtask : t_masks
    task automatic t_cal;
        x_accel_raw <= 14'h0064;
        y_accel_raw <= 14'h012C;
        x_tilt_raw <= 14'h3F9C;
        y_tilt_raw <= 14'h0037;
        wr16(6'h14, 16'h0400);
        wr16(6'h10, 16'h0010);
        wr16(6'h18, 16'h01F0);
        pulse();
        rd_chk("x accel out", 6'h04, 16'h003A);
        rd_chk("y accel out", 6'h06, 16'h012C);
        rd_chk("x tilt out", 6'h0C, 16'hFF8C);
        rd_chk("y tilt out", 6'h0E, 16'h0037);
    endtask : t_cal
    // averaging count set first, as a careful host would
    task automatic t_null;
        wr(6'h38, 8'h08);
        wr(6'h3E, 8'h01);
        rd_chk("x accel null", 6'h10, 16'h0FC6);
        rd_chk("y accel null", 6'h12, 16'h0ED4);
        rd_chk("x tilt null", 6'h18, 16'h0074);
        rd_chk("y tilt null", 6'h1A, 16'h01C9);
        rd_chk("averaging count", 6'h38, 16'h0008);
        pulse();
        rd_chk("x tilt nulled", 6'h0C, 16'h0010);
        rd_chk("y accel nulled", 6'h06, 16'h0000);
    endtask : t_null
    task automatic t_flash;
        int k;
        wr16(6'h1C, 16'h0ABC);
        wr(6'h3E, 8'h08);
        check("busy", {15'h0000, flash_busy_reg}, 16'h0001);
        k = 0;
        while (flash_busy_reg === 1'b1 && k < 100) begin
            @(posedge mclk);
            k++;
        end
        check("busy done", {15'h0000, flash_busy_reg}, 16'h0000);
        wr16(6'h1C, 16'h0123);
        reset <= 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        rd_chk("recalled gain", 6'h1C, 16'h0ABC);
        rd_chk("recalled offset", 6'h10, 16'h0FC6);
        rd_chk("output cleared", 6'h04, 16'h0000);
    endtask : t_flash
    // outputs clamp at the 14-bit limits; a y tilt gain change leaves x accel alone
    task automatic t_sat;
        x_tilt_raw <= 14'h2000;
        y_tilt_raw <= 14'h1F40;
        wr16(6'h1E, 16'h0FFF);
        pulse();
        rd_chk("x tilt low clamp", 6'h0C, 16'hE000);
        rd_chk("y tilt high clamp", 6'h0E, 16'h1FFF);
        rd_chk("x accel kept", 6'h04, 16'h0015);
    endtask : t_sat

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // watchdog: about three times the expected run
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        t_defaults();
        t_masks();
        t_cal();
        t_null();
        t_flash();
        t_sat();
        finish_test();
    end
endmodule : testbench

// [verilog/ioc_cal_lane.sv]
// one calibration lane: output = gain x (raw + offset), saturated to 14 bits
`timescale 1ns/1ps
`include "ioc_map.svh"

module ioc_cal_lane
    import ioc_pkg::*;
#(
    parameter int OFF_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire ioc_sample_t raw,
    input wire logic [OFF_W-1:0] offset_code,
    input wire logic [11:0] gain_code,
    output ioc_sample_t cal_reg
);
    logic signed [14:0] sum;
    logic signed [27:0] prod;
    logic signed [27:0] scaled;
    ioc_sample_t cal_next;

    // ----------------------------------------------------------------
    // arithmetic
    // ----------------------------------------------------------------
    // offset is two's complement, gain straight binary with 0x800 as unity
    always_comb begin
        sum = 15'(raw) + {{(15 - OFF_W){offset_code[OFF_W-1]}}, offset_code};
        prod = sum * $signed({1'b0, gain_code});
        scaled = prod >>> `IOC_GAIN_SHIFT;
        cal_next = cal_reg;
        if (sample_valid) begin
            // clamp rather than wrap, so a large gain cannot flip the sign
            if (scaled > `IOC_OUT_MAX) begin
                cal_next = 14'h1FFF;
            end else if (scaled < `IOC_OUT_MIN) begin
                cal_next = 14'h2000;
            end else begin
                cal_next = scaled[13:0];
            end
        end
    end

    // result register, read back as the output data register
    always_ff @(posedge mclk) begin
        if (reset) begin
            cal_reg <= 14'h0000;
        end else begin
            cal_reg <= cal_next;
        end
    end
endmodule : ioc_cal_lane

// [verilog/ioc_map.svh]
// address map, field layouts, reset values and timing counts of the calibration stage
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define IOC_FRAME_LAST 5'd15
`define IOC_FRAME_DONE 5'd16
`define IOC_WR_BIT 15
`define IOC_ADDR_HI 13
`define IOC_ADDR_LO 8

// ----------------------------------------------------------------
// byte address map (6-bit space)
// ----------------------------------------------------------------
`define IOC_X_ACCEL_OUT 6'h04
`define IOC_Y_ACCEL_OUT 6'h06
`define IOC_X_TILT_OUT 6'h0C
`define IOC_Y_TILT_OUT 6'h0E
`define IOC_X_ACCEL_OFFSET 6'h10
`define IOC_Y_ACCEL_OFFSET 6'h12
`define IOC_X_ACCEL_GAIN 6'h14
`define IOC_Y_ACCEL_GAIN 6'h16
`define IOC_X_TILT_OFFSET 6'h18
`define IOC_Y_TILT_OFFSET 6'h1A
`define IOC_X_TILT_GAIN 6'h1C
`define IOC_Y_TILT_GAIN 6'h1E
`define IOC_AVERAGING_COUNT 6'h38
`define IOC_COMMAND 6'h3E
`define IOC_CAL_HI_NIBBLE 2'h1

// ----------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------
`define IOC_WIDE_MASK 16'h0FFF
`define IOC_NARROW_MASK 16'h01FF
`define IOC_OFFSET_RESET 16'h0000
`define IOC_GAIN_RESET 16'h0800
`define IOC_AVG_RESET 16'h0000
`define IOC_WIDE_OFF_W 12
`define IOC_NARROW_OFF_W 9
`define IOC_WIDE_MAX 15'sh07FF
`define IOC_WIDE_MIN 15'sh7800
`define IOC_NARROW_MAX 15'sh00FF
`define IOC_NARROW_MIN 15'sh7F00

// ----------------------------------------------------------------
// command bits and datapath
// ----------------------------------------------------------------
`define IOC_CMD_NULL_BIT 0
`define IOC_CMD_FLASH_BIT 3
`define IOC_GAIN_SHIFT 11
`define IOC_OUT_MAX 28'sh0001FFF
`define IOC_OUT_MIN 28'shFFFE000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IOC_CLK_NS 10
`define IOC_FLASH_NS 50000
`define IOC_FLASH_CYCLES ((`IOC_FLASH_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)

`endif

// [verilog/ioc_pkg.sv]
// types shared by the calibration stage modules
package ioc_pkg;
    typedef logic [15:0] ioc_word_t;
    typedef logic [5:0] ioc_addr_t;
    typedef logic signed [13:0] ioc_sample_t;
    // flash image handling: recall after reset, idle, commit in progress
    typedef enum logic [1:0] {
        IOC_NV_RESTORE,
        IOC_NV_IDLE,
        IOC_NV_BUSY
    } ioc_nv_state_t;
endpackage : ioc_pkg

// [verilog/ioc_top.sv]
// calibration stage of a dual-axis sensor: serial register port, offset/gain lanes, flash image
//
// Summary of operation
// - registers are 16 bits, two byte addresses
// - fields 12 bits, tilt offsets 9, right-aligned
// - offsets signed, gains unsigned binary
// - output equals gain times (raw plus offset)
// - four outputs have independent offset/gain pairs
// - null command loads offsets with negated outputs
// - all eight calibration registers read and write
// - x accel offset resets zero, 12 bits
// - y accel offset resets zero, 12 bits
// - x accel gain resets unity 0x0800
// - y accel gain resets unity, 12 bits
// - x tilt offset resets zero, 9 bits
// - x tilt gain resets unity, 12 bits
// - calibration values recalled from flash at power-up
// - write frame: bit15 set, address, one byte
// - read returns odd byte then even byte
// - flash commit only on command, 50 us
`timescale 1ns/1ps
`include "ioc_map.svh"

module ioc_top
    import ioc_pkg::*;
#(
    parameter int FLASH_CYCLES = `IOC_FLASH_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_reg,
    input wire logic sample_valid,
    input wire ioc_sample_t x_accel_raw,
    input wire ioc_sample_t y_accel_raw,
    input wire ioc_sample_t x_tilt_raw,
    input wire ioc_sample_t y_tilt_raw,
    output logic flash_busy_reg
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // tilt offsets sit at slots 4 and 5 and are the only 9-bit fields
    function automatic ioc_word_t field_mask(input logic [2:0] slot);
        if (!slot[1] && slot[2]) begin
            return `IOC_NARROW_MASK;
        end
        return `IOC_WIDE_MASK;
    endfunction : field_mask

    // gains sit at slots with bit 1 set and reset to unity, offsets to zero
    function automatic ioc_word_t cal_default(input logic [2:0] slot);
        return slot[1] ? `IOC_GAIN_RESET : `IOC_OFFSET_RESET;
    endfunction : cal_default

    // negate a calibrated output and clamp it into the offset field
    function automatic ioc_word_t null_code(input ioc_sample_t v, input logic narrow);
        logic signed [14:0] n;
        logic signed [14:0] lim_hi;
        logic signed [14:0] lim_lo;
        n = -15'(v);
        lim_hi = narrow ? `IOC_NARROW_MAX : `IOC_WIDE_MAX;
        lim_lo = narrow ? `IOC_NARROW_MIN : `IOC_WIDE_MIN;
        if (n > lim_hi) begin
            n = lim_hi;
        end else if (n < lim_lo) begin
            n = lim_lo;
        end
        return {n[14], n} & (narrow ? `IOC_NARROW_MASK : `IOC_WIDE_MASK);
    endfunction : null_code

    // ----------------------------------------------------------------
    // serial port
    // ----------------------------------------------------------------
    logic sclk_reg, sclk_next;
    logic [15:0] rx_reg, rx_next;
    logic [15:0] tx_reg, tx_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic dout_next;
    logic cmd_valid_reg, cmd_valid_next;
    logic [15:0] cmd_word_reg, cmd_word_next;
    ioc_word_t rd_data_reg, rd_data_next;
    logic sclk_rise;
    logic sclk_fall;

    // sample din on rising sclk, move dout on falling sclk; idle sclk high
    always_comb begin
        sclk_rise = sclk && !sclk_reg;
        sclk_fall = !sclk && sclk_reg;
        sclk_next = sclk;
        rx_next = rx_reg;
        tx_next = tx_reg;
        bit_cnt_next = bit_cnt_reg;
        dout_next = dout_reg;
        cmd_valid_next = 1'b0;
        cmd_word_next = cmd_word_reg;
        if (cs_n) begin
            // between frames the answer of the last read is staged
            bit_cnt_next = 5'd0;
            tx_next = rd_data_reg;
            dout_next = rd_data_reg[15];
        end else begin
            if (sclk_rise && bit_cnt_reg != `IOC_FRAME_DONE) begin
                rx_next = {rx_reg[14:0], din};
                bit_cnt_next = bit_cnt_reg + 5'd1;
                if (bit_cnt_reg == `IOC_FRAME_LAST) begin
                    cmd_valid_next = 1'b1;
                    cmd_word_next = {rx_reg[14:0], din};
                end
            end
            // the first falling edge of a frame precedes any sample
            if (sclk_fall && bit_cnt_reg != 5'd0) begin
                tx_next = {tx_reg[14:0], 1'b0};
                dout_next = tx_reg[14];
            end
        end
    end

    // serial state; sclk_reg resets high so an idle line shows no false edge after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_reg <= 1'b1;
            rx_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            bit_cnt_reg <= 5'd0;
            dout_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_word_reg <= 16'h0000;
        end else begin
            sclk_reg <= sclk_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            bit_cnt_reg <= bit_cnt_next;
            dout_reg <= dout_next;
            cmd_valid_reg <= cmd_valid_next;
            cmd_word_reg <= cmd_word_next;
        end
    end

    // ----------------------------------------------------------------
    // calibration lanes
    // ----------------------------------------------------------------
    ioc_word_t cal_reg [8];
    ioc_sample_t raw_arr [4];
    ioc_sample_t out_arr [4];

    assign raw_arr[0] = x_accel_raw;
    assign raw_arr[1] = y_accel_raw;
    assign raw_arr[2] = x_tilt_raw;
    assign raw_arr[3] = y_tilt_raw;

    // lane i uses offset slot i (+2 for tilt) and the gain two slots above
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            localparam int OSLOT = (gi < 2) ? gi : gi + 2;
            localparam int OW = (gi < 2) ? `IOC_WIDE_OFF_W : `IOC_NARROW_OFF_W;
            ioc_cal_lane #(
                .OFF_W(OW)
            ) u_lane (
                .mclk(mclk),
                .reset(reset),
                .sample_valid(sample_valid),
                .raw(raw_arr[gi]),
                .offset_code(cal_reg[OSLOT][OW-1:0]),
                .gain_code(cal_reg[OSLOT + 2][11:0]),
                .cal_reg(out_arr[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // register file, null command and flash image
    // ----------------------------------------------------------------
    // the image survives reset; it stands for the flash cells
    ioc_word_t nv_image [8] = '{`IOC_OFFSET_RESET, `IOC_OFFSET_RESET, `IOC_GAIN_RESET,
        `IOC_GAIN_RESET, `IOC_OFFSET_RESET, `IOC_OFFSET_RESET, `IOC_GAIN_RESET,
        `IOC_GAIN_RESET};
    ioc_word_t cal_next [8];
    ioc_word_t avg_reg, avg_next;
    ioc_nv_state_t nv_state_reg, nv_state_next;
    logic [12:0] flash_cnt_reg, flash_cnt_next;
    logic flash_busy_next;
    logic img_we;
    ioc_addr_t addr;
    logic [2:0] slot;
    logic is_cal;
    logic [7:0] wbyte;
    ioc_word_t fmask;
    ioc_word_t nv_next [8];

    // decode of the command word latched at the end of the frame
    always_comb begin
        addr = cmd_word_reg[`IOC_ADDR_HI:`IOC_ADDR_LO];
        slot = addr[3:1];
        is_cal = addr[5:4] == `IOC_CAL_HI_NIBBLE;
        wbyte = cmd_word_reg[7:0];
        // bits outside the field are dropped on write and so read back as zero
        fmask = field_mask(slot);
        cal_next = cal_reg;
        nv_next = nv_image;
        avg_next = avg_reg;
        rd_data_next = rd_data_reg;
        nv_state_next = nv_state_reg;
        flash_cnt_next = flash_cnt_reg;
        img_we = 1'b0;
        unique case (nv_state_reg)
            IOC_NV_RESTORE: begin
                // recall lands before a frame can complete, so no write is lost
                cal_next = nv_image;
                nv_state_next = IOC_NV_IDLE;
            end
            IOC_NV_IDLE: begin
                // waits for a commit command
            end
            IOC_NV_BUSY: begin
                // the count wraps below zero, harmless since the state leaves busy then
                flash_cnt_next = flash_cnt_reg - 13'd1;
                if (flash_cnt_reg == 13'd0) begin
                    nv_state_next = IOC_NV_IDLE;
                end
            end
        endcase
        if (cmd_valid_reg && cmd_word_reg[`IOC_WR_BIT]) begin
            // one byte per write; the odd address is the upper byte
            if (is_cal) begin
                if (addr[0]) begin
                    cal_next[slot][15:8] = wbyte & fmask[15:8];
                end else begin
                    cal_next[slot][7:0] = wbyte & fmask[7:0];
                end
            end else if (addr[5:1] == `IOC_AVERAGING_COUNT >> 1) begin
                // stored only; the filter it sets lives outside this stage
                if (addr[0]) begin
                    avg_next[15:8] = wbyte;
                end else begin
                    avg_next[7:0] = wbyte;
                end
            end else if (addr[5:1] == `IOC_COMMAND >> 1 && !addr[0]) begin
                // the gain is not divided out: a non-unity gain leaves a residue
                if (wbyte[`IOC_CMD_NULL_BIT]) begin
                    for (int i = 0; i < 4; i++) begin
                        cal_next[(i < 2) ? i : i + 2] = null_code(out_arr[i], i >= 2);
                    end
                end
                // a second commit while one runs is ignored
                if (wbyte[`IOC_CMD_FLASH_BIT] && nv_state_reg == IOC_NV_IDLE) begin
                    img_we = 1'b1;
                    flash_cnt_next = 13'(FLASH_CYCLES - 1);
                    nv_state_next = IOC_NV_BUSY;
                end
            end
        end else if (cmd_valid_reg) begin
            // read: whole word at the even address, upper byte goes out first
            unique case ({addr[5:1], 1'b0})
                `IOC_X_ACCEL_OUT: rd_data_next = 16'(out_arr[0]);
                `IOC_Y_ACCEL_OUT: rd_data_next = 16'(out_arr[1]);
                `IOC_X_TILT_OUT: rd_data_next = 16'(out_arr[2]);
                `IOC_Y_TILT_OUT: rd_data_next = 16'(out_arr[3]);
                `IOC_AVERAGING_COUNT: rd_data_next = avg_reg;
                // unmapped and write-only addresses read back as zero
                default: rd_data_next = is_cal ? cal_reg[slot] : 16'h0000;
            endcase
        end
        // the commit image is the register file as it stood when the command acted
        if (img_we) begin
            nv_next = cal_reg;
        end
        // busy follows the next state: it rises with the command, falls with the count
        flash_busy_next = nv_state_next == IOC_NV_BUSY;
    end

    // register state; reset restores defaults and the image recall follows
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                cal_reg[i] <= cal_default(3'(i));
            end
            avg_reg <= `IOC_AVG_RESET;
            rd_data_reg <= 16'h0000;
            nv_state_reg <= IOC_NV_RESTORE;
            flash_cnt_reg <= 13'd0;
            flash_busy_reg <= 1'b0;
        end else begin
            cal_reg <= cal_next;
            avg_reg <= avg_next;
            rd_data_reg <= rd_data_next;
            nv_state_reg <= nv_state_next;
            flash_cnt_reg <= flash_cnt_next;
            flash_busy_reg <= flash_busy_next;
        end
    end

    // flash cells: written only by the commit command, untouched by reset
    always_ff @(posedge mclk) begin
        nv_image <= nv_next;
    end
endmodule : ioc_top
